// ---- fabc_top.sv ----
// Purpose: Frame acceptance state machine and back-end buffer control
// Assumes: Validated frames arrive as one-cycle strobes; single pclk domain
// Notes:   Control frames (unlock, preset of expected number) come in as strobes
//
// What this block does
// - Open, expected number, buffer empty: accept, count up, clear retransmit, stay open.
// - Open, expected number, buffer busy: discard, set retransmit and wait, go wait.
// - Number in positive window: discard; open also sets retransmit; else no change.
// - Lockout discards expected-number frames; wait treats free-buffer case impossible.
// - Expedited data always written to buffer, erasing old segment with signalled overwrite.
// - Accepted segment goes to authentication, or segmentation when authentication is off.
// - Arrival means a legal frame in front buffer; buffer allocated only on acceptance.
// - Three states: open, wait with wait flag, lockout with lockout flag.
// - Number outside window sets lockout flag and enters lockout.
// - Number in negative window: discarded, no flag or state change.
// - Wait is left when the higher layer releases the back-end buffer, or for lockout on an out-of-window number.
// - Lockout left only on valid unlock; expedited data still accepted in lockout.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module fabc_top
    import fabc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Frames from the validation stage
    input  wire logic        frame_valid,
    input  wire logic        frame_expedited,
    input  wire logic [7:0]  frame_seq,
    input  wire logic        unlock_cmd,
    input  wire logic        set_vr_cmd,
    input  wire logic [7:0]  set_vr_value,
    // Higher layer
    input  wire logic        buffer_release,
    output logic             segment_to_auth,
    output logic             segment_to_seg,
    output logic             segment_abort,
    output logic             buffer_busy,
    output logic             wait_flag,
    output logic             lockout_flag,
    output logic             retransmit_flag,
    output logic      [7:0]  expected_seq,
    output logic             irq
);

    // ------------------------------------------------------------
    // Window arithmetic
    // ------------------------------------------------------------
    // Modulo-256 distances keep the window correct across wrap
    function automatic fabc_win_t classify(input logic [7:0] ns, input logic [7:0] vr,
                                           input logic [7:0] pw, input logic [7:0] nw);
        logic [7:0] up;
        logic [7:0] down;
        up   = 8'(ns - vr);
        down = 8'(vr - ns);
        if (up == 8'h00) begin
            classify = WIN_EXACT;
        end else if (pw != 8'h00 && up <= 8'(pw - 8'h01)) begin
            classify = WIN_POS;
        end else if (down <= nw) begin
            classify = WIN_NEG;
        end else begin
            classify = WIN_OUT;
        end
    endfunction

    fabc_state_t          state_reg;
    fabc_state_t          state_next;
    logic [7:0]           vr_reg;
    logic [7:0]           vr_next;
    logic                 retx_reg;
    logic                 retx_next;
    logic                 busy_reg;
    logic                 busy_next;
    logic                 to_auth_next;
    logic                 to_seg_next;
    logic                 abort_next;
    logic [EV_COUNT-1:0]  ev;
    logic                 auth_en;
    logic [7:0]           pos_width;
    logic [7:0]           neg_width;
    fabc_win_t            win;
    logic                 accept;
    logic [31:0]          status_word;
    logic                 wait_next;
    logic                 lock_next;

    // ------------------------------------------------------------
    // Acceptance machine
    // ------------------------------------------------------------
    // One frame per strobe; the strobe marks a legal frame in the front buffer
    always_comb begin
        state_next = state_reg;
        vr_next    = vr_reg;
        retx_next  = retx_reg;
        busy_next  = busy_reg;
        abort_next = 1'b0;
        accept     = 1'b0;
        ev         = '0;
        win        = classify(frame_seq, vr_reg, pos_width, neg_width);
        // Release frees the buffer; a same-cycle acceptance refills it below
        if (buffer_release) begin
            busy_next = 1'b0;
            if (state_reg == FABC_WAIT) begin
                state_next = FABC_OPEN;
            end
        end
        if (frame_valid && frame_expedited) begin
            accept    = 1'b1;
            busy_next = 1'b1;
            if (busy_reg && !buffer_release) begin
                abort_next = 1'b1;
                ev[EV_OVERWRITE_BIT] = 1'b1;
            end
        end else if (frame_valid) begin
            case (state_reg)
                FABC_OPEN: begin
                    case (win)
                        WIN_EXACT: begin
                            if (!busy_reg) begin
                                accept    = 1'b1;
                                busy_next = 1'b1;
                                vr_next   = 8'(vr_reg + 8'h01);
                                retx_next = 1'b0;
                                ev[EV_ACCEPT_BIT] = 1'b1;
                            end else begin
                                retx_next  = 1'b1;
                                state_next = FABC_WAIT;
                                ev[EV_NOBUF_BIT] = 1'b1;
                            end
                        end
                        WIN_POS: begin
                            retx_next = 1'b1;
                            ev[EV_POSWIN_BIT] = 1'b1;
                        end
                        WIN_NEG: begin
                            ev[EV_NEGWIN_BIT] = 1'b1;
                        end
                        default: begin
                            state_next = FABC_LOCKOUT;
                            ev[EV_LOCK_BIT] = 1'b1;
                        end
                    endcase
                end
                FABC_WAIT: begin
                    // Free-buffer case cannot occur here: frame is discarded
                    if (win == WIN_OUT) begin
                        state_next = FABC_LOCKOUT;
                        ev[EV_LOCK_BIT] = 1'b1;
                    end
                end
                FABC_LOCKOUT: begin
                    // Every sequenced frame is dropped while locked out
                    state_next = FABC_LOCKOUT;
                end
                default: begin
                    state_next = FABC_OPEN;
                end
            endcase
        end else if (unlock_cmd) begin
            if (state_reg == FABC_LOCKOUT) begin
                state_next = FABC_OPEN;
            end
            retx_next = 1'b0;
        end else if (set_vr_cmd && state_reg != FABC_LOCKOUT) begin
            vr_next   = set_vr_value;
            retx_next = 1'b0;
        end
        to_auth_next = accept && auth_en;
        to_seg_next  = accept && !auth_en;
        wait_next    = (state_next == FABC_WAIT);
        lock_next    = (state_next == FABC_LOCKOUT);
    end

    // Register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= FABC_OPEN;
            vr_reg          <= VR_RESET;
            retx_reg        <= 1'b0;
            busy_reg        <= 1'b0;
            segment_to_auth <= 1'b0;
            segment_to_seg  <= 1'b0;
            segment_abort   <= 1'b0;
            wait_flag       <= 1'b0;
            lockout_flag    <= 1'b0;
        end else begin
            state_reg       <= state_next;
            vr_reg          <= vr_next;
            retx_reg        <= retx_next;
            busy_reg        <= busy_next;
            segment_to_auth <= to_auth_next;
            segment_to_seg  <= to_seg_next;
            segment_abort   <= abort_next;
            wait_flag       <= wait_next;
            lockout_flag    <= lock_next;
        end
    end

    // Remaining outputs are plain copies of registers; pready is tied high
    assign retransmit_flag = retx_reg;
    assign buffer_busy     = busy_reg;
    assign expected_seq    = vr_reg;
    assign pready          = 1'b1;  // Zero wait states keep the slave simple

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_STATE_LSB +: 2] = state_reg;
        status_word[STAT_WAIT_BIT]       = wait_flag;
        status_word[STAT_LOCK_BIT]       = lockout_flag;
        status_word[STAT_RETX_BIT]       = retx_reg;
        status_word[STAT_BUSY_BIT]       = busy_reg;
        status_word[STAT_VR_LSB +: 8]    = vr_reg;
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    fabc_apb_regs u_regs (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pslverr   (pslverr),
        .status_in (status_word),
        .event_in  (ev),
        .auth_en   (auth_en),
        .pos_width (pos_width),
        .neg_width (neg_width),
        .irq       (irq)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_exact_free_open;
        frame_valid && !frame_expedited && !buffer_release && state_reg == FABC_OPEN
        && win == WIN_EXACT && !busy_reg;
    endsequence

    // A sequenced frame meeting a locked-out machine
    sequence seq_seq_frame_locked;
        frame_valid && !frame_expedited && state_reg == FABC_LOCKOUT;
    endsequence

    chk_accept_counts: assert property (@(posedge pclk) disable iff (!presetn)
        seq_exact_free_open |=> vr_reg == 8'($past(vr_reg) + 8'h01) && !retx_reg
        && busy_reg && state_reg == FABC_OPEN && (segment_to_auth || segment_to_seg))
        else $error("in-sequence accept wrong");

    chk_nobuf_wait: assert property (@(posedge pclk) disable iff (!presetn)
        frame_valid && !frame_expedited && !buffer_release && state_reg == FABC_OPEN
        && win == WIN_EXACT && busy_reg |=> wait_flag && retx_reg
        && !segment_to_auth && !segment_to_seg)
        else $error("busy buffer did not enter wait");

    chk_poswin_discard: assert property (@(posedge pclk) disable iff (!presetn)
        frame_valid && !frame_expedited && win == WIN_POS && state_reg == FABC_OPEN
        |=> retx_reg && state_reg == FABC_OPEN && $stable(vr_reg))
        else $error("positive window frame mishandled");

    chk_lockout_holds: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == FABC_LOCKOUT && !unlock_cmd |=> state_reg == FABC_LOCKOUT)
        else $error("lockout left without unlock");

    chk_lockout_discard: assert property (@(posedge pclk) disable iff (!presetn)
        seq_seq_frame_locked |=> lockout_flag && $stable(vr_reg)
        && !segment_to_auth && !segment_to_seg)
        else $error("locked-out frame was not discarded");

    chk_exped_overwrite: assert property (@(posedge pclk) disable iff (!presetn)
        frame_valid && frame_expedited && busy_reg && !buffer_release
        |=> segment_abort && busy_reg && (segment_to_auth || segment_to_seg))
        else $error("expedited overwrite not signalled");

    chk_exped_in_lock: assert property (@(posedge pclk) disable iff (!presetn)
        frame_valid && frame_expedited && state_reg == FABC_LOCKOUT
        |=> lockout_flag && (segment_to_auth || segment_to_seg))
        else $error("expedited frame mishandled in lockout");

    chk_route_auth: assert property (@(posedge pclk) disable iff (!presetn)
        segment_to_auth |-> !segment_to_seg && $past(auth_en))
        else $error("segment routed to wrong layer");

    chk_window_lock: assert property (@(posedge pclk) disable iff (!presetn)
        frame_valid && !frame_expedited && win == WIN_OUT && state_reg != FABC_LOCKOUT
        |=> lockout_flag && !wait_flag)
        else $error("out-of-window frame did not lock");

    chk_flags_state: assert property (@(posedge pclk) disable iff (!presetn)
        wait_flag == (state_reg == FABC_WAIT) && lockout_flag == (state_reg == FABC_LOCKOUT))
        else $error("state flags disagree with state");

    chk_negwin_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        frame_valid && !frame_expedited && win == WIN_NEG && !buffer_release
        |=> $stable(state_reg) && $stable(retx_reg) && $stable(vr_reg))
        else $error("negative window frame changed state");

    chk_wait_release: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == FABC_WAIT && !buffer_release && !frame_valid |=> wait_flag)
        else $error("wait left without release");

endmodule

// ---- fabc_pkg.sv ----
// Purpose: Shared constants and types for the frame acceptance buffer control block
// Assumes: 32-bit APB register bus, one clock domain
// Notes:   Register offsets are byte addresses of aligned words
package fabc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] FABC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] FABC_STATUS_OFS = 8'h04;
    localparam logic [7:0] FABC_IRQ_OFS    = 8'h08;
    localparam logic [7:0] FABC_MASK_OFS   = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Control register
    localparam int CTRL_AUTH_EN_BIT = 0;
    localparam int CTRL_PW_LSB      = 8;
    localparam int CTRL_NW_LSB      = 16;
    // Status register
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_WAIT_BIT    = 2;
    localparam int STAT_LOCK_BIT    = 3;
    localparam int STAT_RETX_BIT    = 4;
    localparam int STAT_BUSY_BIT    = 5;
    localparam int STAT_VR_LSB      = 8;
    // Event bits, shared by status-of-events and mask registers
    localparam int EV_ACCEPT_BIT    = 0;
    localparam int EV_NOBUF_BIT     = 1;
    localparam int EV_POSWIN_BIT    = 2;
    localparam int EV_LOCK_BIT      = 3;
    localparam int EV_OVERWRITE_BIT = 4;
    localparam int EV_NEGWIN_BIT    = 5;
    localparam int EV_COUNT         = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PW_RESET = 8'h0a;
    localparam logic [7:0] NW_RESET = 8'h0a;
    localparam logic       AUTH_EN_RESET = 1'b1;
    localparam logic [7:0] VR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FABC_OPEN    = 2'b01,
        FABC_WAIT    = 2'b10,
        FABC_LOCKOUT = 2'b11
    } fabc_state_t;

    // Classification of a sequenced frame number against the window
    typedef enum logic [1:0] {
        WIN_EXACT = 2'b00,
        WIN_POS   = 2'b01,
        WIN_NEG   = 2'b10,
        WIN_OUT   = 2'b11
    } fabc_win_t;

endpackage

// ---- fabc_apb_regs.sv ----
// Purpose: APB slave holding control, interrupt status and mask registers
// Assumes: Zero-wait-state APB, 32-bit data
// Notes:   Event bits are write-one-to-clear; a new event wins over a clear
`timescale 1ns/1ps
module fabc_apb_regs
    import fabc_pkg::*;
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // Block side
    input  wire logic [31:0]          status_in,
    input  wire logic [EV_COUNT-1:0]  event_in,
    output logic                      auth_en,
    output logic      [7:0]           pos_width,
    output logic      [7:0]           neg_width,
    output logic                      irq
);

    logic [31:0]         ctrl_reg;
    logic [31:0]         ctrl_next;
    logic [EV_COUNT-1:0] ev_reg;
    logic [EV_COUNT-1:0] ev_next;
    logic [EV_COUNT-1:0] mask_reg;
    logic [EV_COUNT-1:0] mask_next;
    logic [31:0]         prdata_next;
    logic                pslverr_next;
    logic                irq_next;
    logic                wr;
    logic                rd;
    logic                mapped;

    // Control word after reset, assembled from the package field positions
    localparam logic [31:0] CTRL_RESET = (32'(NW_RESET) << CTRL_NW_LSB)
                                       | (32'(PW_RESET) << CTRL_PW_LSB)
                                       | (32'(AUTH_EN_RESET) << CTRL_AUTH_EN_BIT);

    // ------------------------------------------------------------
    // Access decode and next values
    // ------------------------------------------------------------
    // Setup-phase decode so read data is ready in the access phase
    always_comb begin
        wr        = psel && penable && pwrite;
        rd        = psel && !penable && !pwrite;
        mapped    = (paddr == FABC_CTRL_OFS) || (paddr == FABC_STATUS_OFS)
                 || (paddr == FABC_IRQ_OFS) || (paddr == FABC_MASK_OFS);
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        ev_next   = ev_reg;
        if (wr && paddr == FABC_CTRL_OFS) begin
            ctrl_next = pwdata;
        end
        if (wr && paddr == FABC_MASK_OFS) begin
            mask_next = pwdata[EV_COUNT-1:0];
        end
        if (wr && paddr == FABC_IRQ_OFS) begin
            ev_next = ev_next & ~pwdata[EV_COUNT-1:0];
        end
        ev_next      = ev_next | event_in;      // Set wins over clear
        prdata_next  = prdata;
        pslverr_next = 1'b0;
        if (rd) begin
            case (paddr)
                FABC_CTRL_OFS:   prdata_next = ctrl_reg;
                FABC_STATUS_OFS: prdata_next = status_in;
                FABC_IRQ_OFS:    prdata_next = {{(32-EV_COUNT){1'b0}}, ev_reg};
                FABC_MASK_OFS:   prdata_next = {{(32-EV_COUNT){1'b0}}, mask_reg};
                default:         prdata_next = 32'h0000_0000;
            endcase
        end
        if (psel && !penable) begin
            pslverr_next = !mapped;
        end
        irq_next = |(ev_next & mask_next);
    end

    // Register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= '0;
            ev_reg   <= '0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
            irq      <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            ev_reg   <= ev_next;
            prdata   <= prdata_next;
            pslverr  <= pslverr_next;
            irq      <= irq_next;
        end
    end

    // Field extraction from control word
    assign auth_en   = ctrl_reg[CTRL_AUTH_EN_BIT];
    assign pos_width = ctrl_reg[CTRL_PW_LSB +: 8];
    assign neg_width = ctrl_reg[CTRL_NW_LSB +: 8];

endmodule

// ---- fabc_higher_layer.sv ----
// Purpose: Behavioural higher layer that reads out and frees the back-end buffer
// Assumes: One pclk domain; release is a one-cycle pulse
// Notes:   rel_delay 4'hf holds the buffer forever, 0 frees it after one cycle, other values free it after that many cycles
`timescale 1ns/1ps
module fabc_higher_layer (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Buffer handshake
    input  wire logic       buffer_busy,
    input  wire logic [3:0] rel_delay,
    output logic            buffer_release
);
    logic [3:0] cnt;

    // ------------------------------------------------------------
    // Read-out delay
    // ------------------------------------------------------------
    // Counting only while busy, so a release never precedes an allocation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt            <= 4'h0;
            buffer_release <= 1'b0;
        end else begin
            buffer_release <= 1'b0;
            if (!buffer_busy || buffer_release || rel_delay == 4'hf) begin
                cnt <= 4'h0;
            end else if (cnt + 4'h1 >= rel_delay) begin
                cnt            <= 4'h0;
                buffer_release <= 1'b1;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// ---- test_frame_acceptance_buffer_control.sv ----
// Purpose: Self-checking bench for the frame acceptance block
// Assumes: Zero-wait APB; frames are one-cycle strobes
// Notes:   Row vector is auth, abort, busy, wait, lockout, retransmit, expected number
`timescale 1ns/1ps
module test_frame_acceptance_buffer_control;
    import fabc_pkg::*;
    typedef struct {logic ex; logic [7:0] sq; logic [13:0] o;} fabc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, frame_seq, set_vr_value, expected_seq;
    logic [31:0] pwdata, prdata, rd;
    logic        frame_valid, frame_expedited, unlock_cmd, set_vr_cmd, buffer_release, er;
    logic        segment_to_auth, segment_to_seg, segment_abort, buffer_busy;
    logic        wait_flag, lockout_flag, retransmit_flag;
    logic [3:0]  rel_delay;
    int          errors, samples_checked, cycles, n;
    fabc_row_t   rows [11] = '{'{0, 8'hff, 14'h0000}, '{0, 8'h05, 14'h0100},
        '{0, 8'h00, 14'h2801}, '{0, 8'h01, 14'h0d01}, '{0, 8'h03, 14'h0d01},
        '{0, 8'h00, 14'h0d01}, '{0, 8'h01, 14'h0d01}, '{1, 8'h00, 14'h3d01},
        '{0, 8'h0b, 14'h0b01}, '{0, 8'h01, 14'h0b01}, '{1, 8'h00, 14'h3b01}};

    fabc_top fabc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_valid(frame_valid), .frame_expedited(frame_expedited),
        .frame_seq(frame_seq), .unlock_cmd(unlock_cmd), .set_vr_cmd(set_vr_cmd),
        .set_vr_value(set_vr_value), .buffer_release(buffer_release),
        .segment_to_auth(segment_to_auth), .segment_to_seg(segment_to_seg),
        .segment_abort(segment_abort), .buffer_busy(buffer_busy), .wait_flag(wait_flag),
        .lockout_flag(lockout_flag), .retransmit_flag(retransmit_flag),
        .expected_seq(expected_seq), .irq(irq));
    fabc_higher_layer fabc_higher_layer_i (.pclk(pclk), .presetn(presetn),
        .buffer_busy(buffer_busy), .rel_delay(rel_delay), .buffer_release(buffer_release));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    task test_done;
        if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the whole request until pready is seen high at an edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // One frame strobe; results are sampled once the answering edge has landed
    task frame(input logic ex, input logic [7:0] sq);
        @(posedge pclk);
        frame_valid     <= 1'b1;
        frame_expedited <= ex;
        frame_seq       <= sq;
        @(posedge pclk);
        frame_valid <= 1'b0;
        #1;
    endtask
    task wait_free;
        n = 0;
        while (buffer_busy !== 1'b0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        #1;
        chk("buffer_busy", 0, buffer_busy);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, frame_valid, frame_expedited} = '0;
        {frame_seq, unlock_cmd, set_vr_cmd, set_vr_value} = '0;
        {errors, samples_checked, cycles} = '0;
        rel_delay = 4'hf;
        presetn   = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, FABC_CTRL_OFS, 0);
        chk("ctrl", 32'h000a0a01, rd);
        apb(0, FABC_STATUS_OFS, 0);
        chk("status", 32'h00000001, rd);
        // Table of frame cases; the buffer is held so it stays occupied
        foreach (rows[i]) begin
            frame(rows[i].ex, rows[i].sq);
            chk("row", rows[i].o, {segment_to_auth, segment_abort, buffer_busy, wait_flag,
                lockout_flag, retransmit_flag, expected_seq});
        end
        apb(0, FABC_STATUS_OFS, 0);
        chk("status", 32'h0000013b, rd);
        apb(0, FABC_IRQ_OFS, 0);
        chk("events", 32'h0000003f, rd);
        chk("irq", 0, irq);
        apb(1, FABC_MASK_OFS, 32'h08);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        apb(1, FABC_IRQ_OFS, 32'h08);
        repeat (2) @(posedge pclk);
        chk("irq", 0, irq);
        apb(0, FABC_IRQ_OFS, 0);
        chk("events", 32'h00000037, rd);
        apb(0, 8'h10, 0);
        chk("unmapped_rd", 32'h0, rd);
        chk("unmapped_err", 32'h1, {31'h0, er});
        // Unlock, then let the higher layer read out the buffer
        @(posedge pclk);
        unlock_cmd <= 1'b1;
        @(posedge pclk);
        unlock_cmd <= 1'b0;
        #1;
        chk("unlock", 3'b000, {lockout_flag, wait_flag, retransmit_flag});
        rel_delay <= 4'h2;
        wait_free();
        apb(1, FABC_CTRL_OFS, 32'h000a0a00);
        frame(0, 8'h01);
        chk("seg_path", 2'b01, {segment_to_auth, segment_to_seg});
        wait_free();
        // Expected number wraps through zero
        @(posedge pclk);
        set_vr_cmd   <= 1'b1;
        set_vr_value <= 8'hff;
        @(posedge pclk);
        set_vr_cmd <= 1'b0;
        frame(0, 8'hff);
        chk("wrap", 8'h00, expected_seq);
        wait_free();
        // Wait state is held until a release frees the buffer
        rel_delay <= 4'hf;
        frame(0, 8'h00);
        frame(0, 8'h01);
        repeat (5) @(posedge pclk);
        chk("held", 1, wait_flag);
        rel_delay <= 4'h1;
        n = 0;
        while (wait_flag !== 1'b0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        #1;
        chk("wait_exit", 2'b00, {wait_flag, lockout_flag});
        // Reset in mid-run restores defaults
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("vr_reset", 8'h00, expected_seq);
        apb(0, FABC_CTRL_OFS, 0);
        chk("ctrl", 32'h000a0a01, rd);
        test_done();
    end
endmodule
